// ---- shared/sscd_pkg.sv ----
// Shared constants for the solenoid SPI configuration decoder.
package sscd_pkg;

    // Frame layout.
    localparam int FRAME_W     = 16;
    localparam int CH_BIT      = 15;
    localparam int CMD_HI      = 14;
    localparam int CMD_LO      = 13;
    localparam int EXT_HI      = 12;
    localparam int EXT_LO      = 11;
    localparam int SEL_HI      = 10;
    localparam int SEL_LO      = 8;
    localparam int VAL_HI      = 7;
    localparam int VAL_LO      = 0;
    localparam int OLSG_BIT    = 12;
    localparam int LOAD_SHORT_FAULT_BIT    = 11;
    localparam int OVERHEAT_FAULT_BIT    = 10;
    localparam int ZERO_HI     = 9;
    localparam int ZERO_LO     = 7;
    localparam int REF_BIT     = 6;
    localparam int FT_BIT      = 5;
    localparam int SR_HI       = 4;
    localparam int SR_LO       = 3;
    localparam int HY_HI       = 2;
    localparam int HY_LO       = 0;
    localparam int ED_BIT      = 12;
    localparam int AMP_HI      = 11;
    localparam int AMP_LO      = 7;
    localparam int RATE_HI     = 6;
    localparam int RATE_LO     = 0;

    // Command types in the two bits below the channel bit.
    typedef enum logic [1:0] {
        CMD_CURRENT  = 2'h0,
        CMD_DITHER   = 2'h1,
        CMD_GENERAL  = 2'h2,
        CMD_READ_ERR = 2'h3
    } sscd_cmd_t;

    // Reset values of the configuration fields, then fixed extension, selector, value and word codes.
    localparam logic       FT_RST    = 1'h0;
    localparam logic [1:0] SR_RST    = 2'h3;
    localparam logic [2:0] HY_RST    = 3'h0;
    localparam logic [4:0] AMP_RST   = 5'h00;
    localparam logic [6:0] RATE_RST  = 7'h00;
    localparam logic [1:0] EXT_NONE  = 2'h0;
    localparam logic [2:0] SEL_REV   = 3'h5;
    localparam logic [7:0] VAL_ZERO  = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // Dither period timing.
    localparam int          SYS_CLK_KHZ  = 100000;
    localparam int          BASE_CLK_KHZ = 1760;
    localparam int          BASE_DIV     = SYS_CLK_KHZ / BASE_CLK_KHZ;
    localparam logic [5:0]  BASE_DIV_M1  = 6'(BASE_DIV - 1);
    localparam logic [15:0] DITHER_MULT  = 16'h0150;
    localparam logic [15:0] PCNT_ONE     = 16'h0001;

    // Error register store geometry.
    localparam int MEM_AW = 4;
    localparam int MEM_DW = 8;
    localparam int MEM_N  = 16;

endpackage : sscd_pkg

// ---- design/sscd_err_mem.sv ----
// Small store for the per-channel error correction bytes, registered read.
`timescale 1ns/1ps
module sscd_err_mem
    import sscd_pkg::*;
(
    // Clock and reset.
    input  wire logic              sys_clk_i,
    input  wire logic              rstn_i,
    // Write port.
    input  wire logic              wr_en_i,
    input  wire logic [MEM_AW-1:0] wr_addr_i,
    input  wire logic [MEM_DW-1:0] wr_data_i,
    // Read port.
    input  wire logic              rd_en_i,
    input  wire logic [MEM_AW-1:0] rd_addr_i,
    output logic      [MEM_DW-1:0] rd_data_o
);

    typedef struct packed {
        logic [MEM_N-1:0][MEM_DW-1:0] mem;
        logic [MEM_DW-1:0]            q;
    } sscd_mem_t;

    sscd_mem_t mem_reg;
    sscd_mem_t mem_next;

    always_comb
    begin
        mem_next = mem_reg;
        if (wr_en_i)
        begin
            mem_next.mem[wr_addr_i] = wr_data_i;
        end
        if (rd_en_i)
        begin
            mem_next.q = mem_reg.mem[rd_addr_i];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            mem_reg <= '0;
        end
        else
        begin
            mem_reg <= mem_next;
        end
    end

    assign rd_data_o = mem_reg.q;

endmodule : sscd_err_mem

// ---- design/sscd_decoder.sv ----
// SPI frame decoder holding both channels' configuration and dither timing.
`timescale 1ns/1ps
module sscd_decoder
    import sscd_pkg::*;
#(
    // Revision byte; the value is arbitrary.
    parameter logic [7:0] CHIP_REV = 8'h5a
)
(
    // System clock and reset.
    input  wire logic            sys_clk_i,
    input  wire logic            rstn_i,
    // SPI link.
    input  wire logic            spi_clk_i,
    input  wire logic            chip_select_n_i,
    input  wire logic            mosi_i,
    output logic                 miso_o,
    // Device pins and analog status.
    input  wire logic            default_n_i,
    input  wire logic [1:0]      open_or_ground_fault_i,
    input  wire logic [1:0]      load_short_fault_i,
    input  wire logic [1:0]      overheat_fault_i,
    input  wire logic            ext_ref_detected_i,
    // Correction trim load.
    input  wire logic            trim_wr_i,
    input  wire logic            trim_ch_i,
    input  wire logic [2:0]      trim_sel_i,
    input  wire logic [7:0]      trim_data_i,
    // Channel controls.
    output logic [1:0]           fault_type_probe_o,
    output logic [1:0][1:0]      edge_rate_sel_o,
    output logic [1:0][2:0]      hysteresis_sel_o,
    output logic [1:0]           enh_dither_o,
    output logic [1:0][4:0]      dither_amp_o,
    output logic [1:0][6:0]      dither_rate_o,
    output logic [1:0]           dither_period_start_o,
    output logic                 frame_invalid_o
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_APPLY = 3'b010,
        ST_REPLY = 3'b100
    } sscd_state_t;

    typedef struct packed {
        logic              dflt_s1;
        logic              dflt_s2;
        logic              cs_s1;
        logic              cs_s2;
        logic              cs_s3;
        logic [6:0]        pin_s1;
        logic [6:0]        pin_s2;
        sscd_state_t       st;
        logic [15:0]       word;
        logic [1:0]        ft;
        logic [1:0][1:0]   sr;
        logic [1:0][2:0]   hy;
        logic [1:0]        ed;
        logic [1:0][4:0]   amp_sh;
        logic [1:0][4:0]   amp_act;
        logic [1:0][6:0]   rate_sh;
        logic [1:0][6:0]   rate_act;
        logic [5:0]        div;
        logic [1:0][15:0]  pcnt;
        logic [1:0]        pstart;
        logic [15:0]       tx;
        logic              invalid;
    } sscd_sys_t;

    typedef struct packed {
        logic [4:0] cnt;
    } sscd_link_t;

    sscd_sys_t   sys_reg;
    sscd_sys_t   sys_next;
    sscd_link_t  link_reg;
    logic [15:0] rx_shift_reg;
    logic [7:0]  mem_q;
    logic        mem_rd;
    logic        frame_end;
    logic        w_ch;
    logic [1:0]  w_cmd;
    logic [1:0]  w_ext;
    logic [2:0]  w_sel;

    function automatic logic [15:0] period_len(input logic [6:0] code);
        period_len = 16'({9'h000, code} * DITHER_MULT);
    endfunction : period_len

    // Link side: bits enter MSB first on the rising edge. Chip select high
    // clears the bit count, since the link clock stops between frames.
    always_ff @(posedge spi_clk_i or posedge chip_select_n_i)
    begin
        if (chip_select_n_i)
        begin
            link_reg.cnt <= 5'h00;
        end
        else if (!link_reg.cnt[4])
        begin
            link_reg.cnt <= link_reg.cnt + 5'h01;
        end
    end

    always_ff @(posedge spi_clk_i)
    begin
        rx_shift_reg <= {rx_shift_reg[14:0], mosi_i};
    end

    // The reply word is static during a frame; after 16 bits the received
    // stream passes straight through for daisy chaining.
    assign miso_o = chip_select_n_i ? 1'b0 :
                    link_reg.cnt[4] ? rx_shift_reg[15] :
                    sys_reg.tx[4'hf - link_reg.cnt[3:0]];

    assign frame_end = sys_reg.cs_s2 && !sys_reg.cs_s3;
    assign w_ch      = sys_reg.word[CH_BIT];
    assign w_cmd     = sys_reg.word[CMD_HI:CMD_LO];
    assign w_ext     = sys_reg.word[EXT_HI:EXT_LO];
    assign w_sel     = sys_reg.word[SEL_HI:SEL_LO];
    assign mem_rd    = (sys_reg.st == ST_APPLY);

    sscd_err_mem u_err_mem (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .wr_en_i   (trim_wr_i),
        .wr_addr_i ({trim_ch_i, trim_sel_i}),
        .wr_data_i (trim_data_i),
        .rd_en_i   (mem_rd),
        .rd_addr_i ({w_ch, w_sel}),
        .rd_data_o (mem_q)
    );

    always_comb
    begin
        sys_next         = sys_reg;
        sys_next.pstart  = 2'b00;
        sys_next.invalid = 1'b0;
        sys_next.dflt_s1 = default_n_i;
        sys_next.dflt_s2 = sys_reg.dflt_s1;
        sys_next.cs_s1   = chip_select_n_i;
        sys_next.cs_s2   = sys_reg.cs_s1;
        sys_next.cs_s3   = sys_reg.cs_s2;
        sys_next.pin_s1  = {ext_ref_detected_i, overheat_fault_i,
                            load_short_fault_i, open_or_ground_fault_i};
        sys_next.pin_s2  = sys_reg.pin_s1;
        sys_next.div     = (sys_reg.div == BASE_DIV_M1) ? 6'h00 : sys_reg.div + 6'h01;

        case (sys_reg.st)
            ST_IDLE:
            begin
                // The link clock has stopped by now, so the word is stable.
                if (frame_end)
                begin
                    sys_next.word = rx_shift_reg;
                    sys_next.st   = ST_APPLY;
                end
            end
            ST_APPLY:
            begin
                case (w_cmd)
                    CMD_GENERAL:
                    begin
                        // Bits above the hysteresis, edge rate and probe fields are unused.
                        sys_next.ft[w_ch] = sys_reg.word[FT_BIT];
                        sys_next.sr[w_ch] = sys_reg.word[SR_HI:SR_LO];
                        sys_next.hy[w_ch] = sys_reg.word[HY_HI:HY_LO];
                    end
                    CMD_DITHER:
                    begin
                        sys_next.ed[w_ch]      = sys_reg.word[ED_BIT];
                        sys_next.amp_sh[w_ch]  = sys_reg.word[AMP_HI:AMP_LO];
                        sys_next.rate_sh[w_ch] = sys_reg.word[RATE_HI:RATE_LO];
                    end
                    CMD_READ_ERR:
                    begin
                        sys_next.invalid = (w_ext != EXT_NONE);
                    end
                    default:
                    begin
                        sys_next.invalid = 1'b0;
                    end
                endcase
                sys_next.st = ST_REPLY;
            end
            ST_REPLY:
            begin
                case (w_cmd)
                    CMD_GENERAL:
                    begin
                        sys_next.tx = {w_ch, w_cmd,
                                       sys_reg.pin_s2[{2'b00, w_ch}],
                                       sys_reg.pin_s2[3'h2 + {2'b00, w_ch}],
                                       sys_reg.pin_s2[3'h4 + {2'b00, w_ch}],
                                       3'h0,
                                       !sys_reg.pin_s2[6],
                                       sys_reg.ft[w_ch], sys_reg.sr[w_ch],
                                       sys_reg.hy[w_ch]};
                    end
                    CMD_DITHER:
                    begin
                        sys_next.tx = {w_ch, w_cmd, sys_reg.ed[w_ch],
                                       sys_reg.amp_sh[w_ch], sys_reg.rate_sh[w_ch]};
                    end
                    CMD_READ_ERR:
                    begin
                        if (w_ext != EXT_NONE)
                        begin
                            sys_next.tx = WORD_ZERO;
                        end
                        else
                        begin
                            // Shifted out in the next frame.
                            sys_next.tx = {w_ch, w_cmd, EXT_NONE, w_sel,
                                           (w_sel < SEL_REV) ? mem_q :
                                           (w_sel == SEL_REV) ? CHIP_REV :
                                           VAL_ZERO};
                        end
                    end
                    default:
                    begin
                        sys_next.tx = WORD_ZERO;
                    end
                endcase
                sys_next.st = ST_IDLE;
            end
            default:
            begin
                sys_next.st = ST_IDLE;
            end
        endcase

        // A channel with dither off takes new settings at the next base tick; a running
        // one waits for its period to close.
        for (int c = 0; c < 2; c++)
        begin
            if (sys_reg.div == BASE_DIV_M1)
            begin
                if (sys_reg.rate_act[c] == RATE_RST)
                begin
                    sys_next.rate_act[c] = sys_reg.rate_sh[c];
                    sys_next.amp_act[c]  = sys_reg.amp_sh[c];
                    sys_next.pcnt[c]     = 16'h0000;
                end
                else if (sys_reg.pcnt[c] == period_len(sys_reg.rate_act[c]) - PCNT_ONE)
                begin
                    sys_next.pcnt[c]     = 16'h0000;
                    sys_next.pstart[c]   = 1'b1;
                    sys_next.rate_act[c] = sys_reg.rate_sh[c];
                    sys_next.amp_act[c]  = sys_reg.amp_sh[c];
                end
                else
                begin
                    sys_next.pcnt[c] = sys_reg.pcnt[c] + PCNT_ONE;
                end
            end
        end

        if (!sys_reg.dflt_s2)
        begin
            sys_next.ft       = {2{FT_RST}};
            sys_next.sr       = {2{SR_RST}};
            sys_next.hy       = {2{HY_RST}};
            sys_next.ed       = 2'b00;
            sys_next.amp_sh   = {2{AMP_RST}};
            sys_next.amp_act  = {2{AMP_RST}};
            sys_next.rate_sh  = {2{RATE_RST}};
            sys_next.rate_act = {2{RATE_RST}};
            sys_next.pcnt     = '0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            sys_reg       <= '0;
            sys_reg.sr    <= {2{SR_RST}};
            sys_reg.st    <= ST_IDLE;
            sys_reg.cs_s1 <= 1'b1;
            sys_reg.cs_s2 <= 1'b1;
            sys_reg.cs_s3 <= 1'b1;
        end
        else
        begin
            sys_reg <= sys_next;
        end
    end

    assign fault_type_probe_o    = sys_reg.ft;
    assign edge_rate_sel_o       = sys_reg.sr;
    assign hysteresis_sel_o      = sys_reg.hy;
    assign enh_dither_o          = sys_reg.ed;
    assign dither_amp_o          = sys_reg.amp_act;
    assign dither_rate_o         = sys_reg.rate_act;
    assign dither_period_start_o = sys_reg.pstart;
    assign frame_invalid_o       = sys_reg.invalid;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_frame_end;
        (sys_reg.st == ST_IDLE) && frame_end;
    endsequence

    sequence s_apply(logic [1:0] cmd);
        (sys_reg.st == ST_APPLY) && (w_cmd == cmd) && sys_reg.dflt_s2;
    endsequence

    sequence s_reply(logic [1:0] cmd);
        (sys_reg.st == ST_REPLY) && (w_cmd == cmd);
    endsequence

    property p_cfg_low_bits;
        logic ch_v;
        logic [15:0] w_v;
        (s_apply(CMD_GENERAL), ch_v = w_ch, w_v = sys_reg.word) |=>
            {sys_reg.ft[ch_v], sys_reg.sr[ch_v], sys_reg.hy[ch_v]} == w_v[FT_BIT:HY_LO];
    endproperty

    property p_hyst_prompt;
        logic ch_v;
        logic [2:0] h_v;
        (s_frame_end ##1 (s_apply(CMD_GENERAL), ch_v = w_ch,
            h_v = sys_reg.word[HY_HI:HY_LO])) |=> (sys_reg.hy[ch_v] == h_v);
    endproperty

    AST_CFG_LOW_BITS: assert property (p_cfg_low_bits)
        else $error("General write did not store bits 5..0.");
    AST_FT_WRITE: assert property ((s_apply(CMD_GENERAL) ##0 !w_ch) |=>
        (sys_reg.ft[0] == $past(sys_reg.word[FT_BIT])))
        else $error("Fault type probe not written.");
    AST_SR_WRITE: assert property ((s_apply(CMD_GENERAL) ##0 w_ch) |=>
        (edge_rate_sel_o[1] == $past(sys_reg.word[SR_HI:SR_LO])))
        else $error("Edge rate select not written.");
    AST_HYST_PROMPT: assert property (p_hyst_prompt)
        else $error("Hysteresis not applied right after chip select rise.");
    AST_GEN_FAULTS: assert property (s_reply(CMD_GENERAL) |=>
        (sys_reg.tx[OLSG_BIT] == $past(sys_reg.pin_s2[{2'b00, w_ch}])))
        else $error("Open or ground fault missing from reply.");
    AST_GEN_ZEROS: assert property (s_reply(CMD_GENERAL) |=>
        (sys_reg.tx[ZERO_HI:ZERO_LO] == 3'h0) && (sys_reg.tx[REF_BIT] == !$past(sys_reg.pin_s2[6])))
        else $error("General reply zero or reference bits wrong.");
    AST_READ_EXT: assert property ((s_reply(CMD_READ_ERR) ##0 (w_ext == EXT_NONE)) |=>
        (sys_reg.tx[EXT_HI:EXT_LO] == EXT_NONE) && (sys_reg.tx[SEL_HI:SEL_LO] == $past(w_sel)))
        else $error("Read reply extension or selector wrong.");
    AST_READ_REV: assert property ((s_reply(CMD_READ_ERR) ##0 ((w_ext == EXT_NONE) &&
        (w_sel == SEL_REV))) |=> (sys_reg.tx[VAL_HI:VAL_LO] == CHIP_REV))
        else $error("Revision selector did not return revision byte.");
    AST_INVALID: assert property ((sys_reg.st == ST_APPLY) && (w_cmd == CMD_READ_ERR) &&
        (w_ext != EXT_NONE) |=> frame_invalid_o ##1 (sys_reg.tx != 16'hffff))
        else $error("Invalid frame not flagged or reply all ones.");
    AST_DITHER_SHADOW: assert property ($changed(sys_reg.rate_act[0]) |->
        (sys_reg.pstart[0] || ($past(sys_reg.rate_act[0]) == RATE_RST) || !$past(sys_reg.dflt_s2)))
        else $error("Dither rate changed mid period.");
    AST_PERIOD: assert property (sys_reg.pstart[0] |->
        ($past(sys_reg.pcnt[0]) == period_len($past(sys_reg.rate_act[0])) - PCNT_ONE))
        else $error("Dither period length wrong.");
    AST_DEFAULTS: assert property (!sys_reg.dflt_s2 |=>
        (edge_rate_sel_o == {2{SR_RST}}) && (hysteresis_sel_o == {2{HY_RST}}) &&
        (fault_type_probe_o == 2'b00))
        else $error("Default input did not restore fields.");

endmodule : sscd_decoder

// ---- testbench/sscd_spi_host.sv ----
// SPI host model: a mode 0 master whose clock runs only inside a frame.
`timescale 1ns/1ps
module sscd_spi_host
#(
    parameter int HALF_NS = 40
)
(
    // SPI link.
    output logic      spi_clk_o,
    output logic      chip_select_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial
    begin
        spi_clk_o       = 1'b0;
        chip_select_n_o = 1'b1;
        mosi_o          = 1'b0;
    end

    // Data changes on the falling edge and the reply bit is taken just before each rise.
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #7;
        chip_select_n_o = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o = tx[i];
            #(HALF_NS);
            rx[i] = miso_i;
            spi_clk_o = 1'b1;
            #(HALF_NS);
            spi_clk_o = 1'b0;
        end
        #(HALF_NS);
        chip_select_n_o = 1'b1;
        // A released data line must not keep looking like valid data.
        mosi_o = ~mosi_o;
        // Long chip select high time so the reply is loaded before the next frame.
        #200;
    endtask : xfer
endmodule : sscd_spi_host

// ---- testbench/testbench.sv ----
// Self-checking bench for the SPI configuration decoder.
`timescale 1ns/1ps
module testbench
    import sscd_pkg::*;
;
    // Revision byte handed to the design; the value is arbitrary.
    localparam logic [7:0] REV = 8'h5a;
    logic            sys_clk_i = 1'b0;
    logic            rstn_i, default_n_i, ext_ref, trim_wr, trim_ch, inv_seen;
    logic [1:0]      ogf, short_f, hot;
    logic [2:0]      trim_sel;
    logic [7:0]      trim_data;
    logic            spi_clk, cs_n, mosi, miso, frame_invalid;
    logic [1:0]      probe, enh, pstart;
    logic [1:0][1:0] edge_rate;
    logic [1:0][2:0] hyst;
    logic [1:0][4:0] amp;
    logic [1:0][6:0] rate;
    logic [15:0]     rx;
    int              fails, comparisons, n;

    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (frame_invalid === 1'b1) inv_seen <= 1'b1;

    sscd_spi_host host_u (.spi_clk_o(spi_clk), .chip_select_n_o(cs_n), .mosi_o(mosi),
                          .miso_i(miso));
    sscd_decoder #(.CHIP_REV(REV)) dut_u (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .spi_clk_i(spi_clk),
        .chip_select_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .default_n_i(default_n_i),
        .open_or_ground_fault_i(ogf), .load_short_fault_i(short_f), .overheat_fault_i(hot),
        .ext_ref_detected_i(ext_ref), .trim_wr_i(trim_wr), .trim_ch_i(trim_ch),
        .trim_sel_i(trim_sel), .trim_data_i(trim_data), .fault_type_probe_o(probe),
        .edge_rate_sel_o(edge_rate), .hysteresis_sel_o(hyst), .enh_dither_o(enh),
        .dither_amp_o(amp), .dither_rate_o(rate), .dither_period_start_o(pstart),
        .frame_invalid_o(frame_invalid));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask : cyc

    // Counts system cycles up to and including the next period start pulse of channel 0.
    task automatic wait_pulse(output int k);
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end while (pstart[0] !== 1'b1 && k < 40000);
        if (pstart[0] !== 1'b1)
        begin
            fails++;
            $display("[ERR] period_start expected 1 seen %b", pstart[0]);
        end
    endtask : wait_pulse

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial
    begin
        // The longest scenario spans three dither periods, about 76k cycles.
        #950_000;
        fails++;
        $display("[ERR] watchdog expected finish seen timeout");
        stop_test();
    end

    initial
    begin
        {rstn_i, trim_wr, trim_ch, trim_sel, trim_data, ogf, short_f, hot, ext_ref} = '0;
        default_n_i = 1'b1;
        inv_seen    = 1'b0;
        cyc(4);
        rstn_i <= 1'b1;
        ogf <= 2'b01;
        short_f <= 2'b10;
        hot <= 2'b01;
        cyc(3);
        chk("edge_rate", 16'h000f, 16'(edge_rate));
        chk("hyst", 16'h0000, 16'(hyst));
        chk("probe", 16'h0000, 16'(probe));
        host_u.xfer(16'h5fed, rx);
        chk("probe", 16'h0001, 16'(probe));
        chk("edge_rate", 16'h000d, 16'(edge_rate));
        chk("hyst", 16'h0005, 16'(hyst));
        host_u.xfer(16'hc007, rx);
        chk("general_reply_ch0", 16'h546d, rx);
        chk("hyst", 16'h003d, 16'(hyst));
        @(posedge sys_clk_i);
        {trim_wr, trim_ch, trim_sel, trim_data} <= {1'b1, 1'b0, 3'h2, 8'ha7};
        @(posedge sys_clk_i);
        trim_wr <= 1'b0;
        host_u.xfer(16'h62ff, rx);
        chk("general_reply_ch1", 16'hc847, rx);
        host_u.xfer(16'he500, rx);
        chk("read_reply_sel2", 16'h62a7, rx);
        host_u.xfer(16'h6600, rx);
        chk("read_reply_rev", {8'he5, REV}, rx);
        host_u.xfer(16'h0000, rx);
        chk("read_reply_sel6", 16'h6600, rx);
        chk("invalid_idle", 16'h0000, 16'(inv_seen));
        host_u.xfer(16'h6800, rx);
        host_u.xfer(16'h0000, rx);
        chk("invalid_flag", 16'h0001, 16'(inv_seen));
        chk("invalid_not_ones", 16'h0000, 16'(rx === 16'hffff));
        chk("invalid_reply", 16'h0000, rx);
        host_u.xfer(16'h2181, rx);
        chk("current_reply", 16'h0000, rx);
        cyc(120);
        chk("rate_applied", 16'h0001, 16'(rate[0]));
        chk("amp_applied", 16'h0003, 16'(amp[0]));
        wait_pulse(n);
        host_u.xfer(16'h3102, rx);
        chk("dither_reply", 16'h2181, rx);
        chk("enh", 16'h0001, 16'(enh));
        chk("rate_held", 16'h0001, 16'(rate[0]));
        wait_pulse(n);
        chk("rate_new", 16'h0002, 16'(rate[0]));
        chk("amp_new", 16'h0002, 16'(amp[0]));
        wait_pulse(n);
        chk("period", 16'(2 * 336 * BASE_DIV), 16'(n));
        @(posedge sys_clk_i);
        default_n_i <= 1'b0;
        cyc(6);
        chk("dflt_probe", 16'h0000, 16'(probe));
        chk("dflt_edge", 16'h000f, 16'(edge_rate));
        chk("dflt_hyst", 16'h0000, 16'(hyst));
        chk("dflt_rate", 16'h0000, 16'(rate));
        chk("dflt_enh", 16'h0000, 16'(enh));
        default_n_i <= 1'b1;
        cyc(4);
        stop_test();
    end
endmodule : testbench
